// ---- hw/gpdc_top.sv ----
// gate pre-driver control: phase gating, overlap detection, pump switch, relays, AHB-Lite registers
`timescale 1ns/100ps
// Overview of operation
// RQ1: pump stops while high-side pump voltage reaches battery plus margin.
// RQ2: pump supply switch opens whenever VCC undervoltage is detected.
// RQ3: software bit commands the pump supply switch off.
// RQ4: pump stays stopped whenever the supply switch is off.
// RQ5: relay outputs low when relay enable low, else follow own command bit.
// RQ6: three high and three low channels, each from its own input.
// RQ7: two-bit limit code; 11 none, 00-10 limit for a period after transitions.
// RQ8: phase enable low forces both gates of that phase low.
// RQ9: enabled phase without both inputs high, gates follow inputs.
// RQ10: both inputs high, inhibit-disable low: both gates forced low.
// RQ11: inhibit case sets overlap error only with option bit, even when disabled.
// RQ12: inhibit-disable high: no detection, both high drives both gates high.
// RQ13: diagnosis pin follows the overlap error bits.
// RQ14: overlap error stays set until software writes its clear bit.
// RQ15: mid-supply resistor connected only during initial diagnosis.
// RQ16: settings and status clocked, reset by power-on reset.
module gpdc_top #(
	parameter int NPH = 3
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire gpdc_pkg::gpdc_pair_t [2:0] phase_in,
	input wire logic [2:0] gate_en,
	input wire logic gate_en_relay,
	input wire logic vcc_undervoltage,
	input wire logic pump_overvoltage,
	input wire logic initial_diag_active,
	output gpdc_pkg::gpdc_pair_t [2:0] phase_gate,
	output logic [2:0] relay_out,
	output logic pump_switch_on,
	output logic pump_run,
	output logic current_limit_on,
	output logic midpoint_resistor_on,
	output logic diagnosis_pin_n,
	output logic irq
);
	import gpdc_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (NPH != 3) begin : g_bad_nph
		$error("gpdc_top supports exactly three phases");
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic next_wr_pend;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_ok;
	logic wr_ctrl, wr_ovl, wr_stat, wr_mask;

	gpdc_ctrl_t ctrl, next_ctrl;
	logic [2:0] inhibit_dis, next_inhibit_dis;
	logic flag_option, next_flag_option;
	logic [2:0] ovl_err, next_ovl_err;
	logic [2:0] mask, next_mask;
	logic [2:0] ovl_set;

	// address phase is captured; only whole-word accesses are decoded
	always_comb begin
		addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == 3'h2;
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = haddr[ADDR_W-1:0];
		next_hrdata = hrdata;
		if (addr_ok && !hwrite) begin
			next_hrdata = 32'h0;
			case (haddr[ADDR_W-1:0])
				ADDR_PUMP_RELAY: next_hrdata[5:0] = {ctrl.limit_time, ctrl.relay_cmd, ctrl.pump_off};
				ADDR_OVERLAP: next_hrdata[3:0] = {flag_option, inhibit_dis};
				ADDR_STATUS: begin
					next_hrdata[2:0] = ovl_err;
					next_hrdata[BIT_PUMP_RUN] = pump_run;
					next_hrdata[BIT_PUMP_SW] = pump_switch_on;
				end
				ADDR_MASK: next_hrdata[2:0] = mask;
				default: next_hrdata = 32'h0; // unmapped reads zero
			endcase
		end
		wr_ctrl = wr_pend && wr_addr == ADDR_PUMP_RELAY;
		wr_ovl = wr_pend && wr_addr == ADDR_OVERLAP;
		wr_stat = wr_pend && wr_addr == ADDR_STATUS;
		wr_mask = wr_pend && wr_addr == ADDR_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1; // zero-wait slave, always OKAY
			hresp <= HRESP_OKAY[0];
		end
	end

	// ------------------------------------------------------------
	// settings and overlap status
	// ------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_inhibit_dis = inhibit_dis;
		next_flag_option = flag_option;
		next_mask = mask;
		if (wr_ctrl) begin
			next_ctrl.pump_off = hwdata[BIT_PUMP_OFF]; // see RQ3
			next_ctrl.relay_cmd = hwdata[BIT_RELAY_LO +: 3];
			next_ctrl.limit_time = hwdata[BIT_LIMIT_LO +: 2];
		end
		if (wr_ovl) begin
			next_inhibit_dis = hwdata[2:0];
			next_flag_option = hwdata[BIT_OPTION];
		end
		if (wr_mask)
			next_mask = hwdata[2:0];
		// a fresh overlap wins over a clear in the same cycle
		next_ovl_err = (ovl_err & ~(wr_stat ? hwdata[2:0] : 3'h0)) | ovl_set; // see RQ14
	end

	always_ff @(posedge hclk or negedge hresetn) begin // see RQ16
		if (!hresetn) begin
			ctrl <= '{pump_off: 1'b0, relay_cmd: 3'h0, limit_time: LIMIT_RESET};
			inhibit_dis <= 3'h0;
			flag_option <= 1'b0;
			ovl_err <= 3'h0;
			mask <= 3'h0;
		end else begin
			ctrl <= next_ctrl;
			inhibit_dis <= next_inhibit_dis;
			flag_option <= next_flag_option;
			ovl_err <= next_ovl_err;
			mask <= next_mask;
		end
	end

	// ------------------------------------------------------------
	// phase gating, one slice per phase
	// ------------------------------------------------------------
	gpdc_pair_t [2:0] next_gate;

	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic both;
		assign both = phase_in[p].high && phase_in[p].low;
		// overlap counts even with the phase disabled
		assign ovl_set[p] = both && !inhibit_dis[p] && flag_option; // see RQ11
		always_comb begin
			if (!gate_en[p])
				next_gate[p] = '{high: 1'b0, low: 1'b0}; // see RQ8
			else if (both && !inhibit_dis[p])
				next_gate[p] = '{high: 1'b0, low: 1'b0}; // see RQ10
			else
				next_gate[p] = phase_in[p]; // see RQ9 see RQ12 see RQ6
		end
	end

	// ------------------------------------------------------------
	// current-limit timer, pump, relays, diagnosis
	// ------------------------------------------------------------
	logic [LIMIT_CNT_W-1:0] limit_cnt, next_limit_cnt;
	logic next_pump_sw, next_pump_run;
	logic [2:0] next_relay;

	function automatic logic [LIMIT_CNT_W-1:0] limit_cycles(input logic [1:0] code);
		case (code)
			2'h0: limit_cycles = LIMIT_CNT_W'(LIMIT_CODE0_CYC);
			2'h1: limit_cycles = LIMIT_CNT_W'(LIMIT_CODE1_CYC);
			2'h2: limit_cycles = LIMIT_CNT_W'(LIMIT_CODE2_CYC);
			default: limit_cycles = '0;
		endcase
	endfunction : limit_cycles

	always_comb begin
		// timer restarts on any gate edge; code 11 keeps the preset current
		if (ctrl.limit_time == LIMIT_NONE)
			next_limit_cnt = '0; // see RQ7
		else if (next_gate != phase_gate)
			next_limit_cnt = limit_cycles(ctrl.limit_time); // see RQ7
		else if (limit_cnt != '0)
			next_limit_cnt = limit_cnt - 1'b1;
		else
			next_limit_cnt = '0;
		next_pump_sw = !vcc_undervoltage && !ctrl.pump_off; // see RQ2 see RQ3
		next_pump_run = next_pump_sw && !pump_overvoltage; // see RQ1 see RQ4
		next_relay = gate_en_relay ? ctrl.relay_cmd : 3'h0; // see RQ5
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_gate <= '0;
			limit_cnt <= '0;
			current_limit_on <= 1'b0;
			pump_switch_on <= 1'b0;
			pump_run <= 1'b0;
			relay_out <= 3'h0;
			midpoint_resistor_on <= 1'b0;
			diagnosis_pin_n <= 1'b1;
			irq <= 1'b0;
		end else begin
			phase_gate <= next_gate;
			limit_cnt <= next_limit_cnt;
			current_limit_on <= next_limit_cnt != '0;
			pump_switch_on <= next_pump_sw;
			pump_run <= next_pump_run;
			relay_out <= next_relay;
			midpoint_resistor_on <= initial_diag_active; // see RQ15
			diagnosis_pin_n <= ~|next_ovl_err; // see RQ13
			irq <= |(next_ovl_err & next_mask);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_both_inhibit(int p);
		phase_in[p].high && phase_in[p].low && !inhibit_dis[p];
	endsequence

	a_disabled_gates_low: assert property (!gate_en[0] |=> !phase_gate[0].high && !phase_gate[0].low) // see RQ8
		else $error("disabled phase drives a gate");
	a_inhibit_gates_low: assert property (s_both_inhibit(1) |=> phase_gate[1] == 2'h0) // see RQ10
		else $error("inhibited phase drives a gate");
	a_follow_inputs: assert property (gate_en[2] && !(phase_in[2].high && phase_in[2].low)
		|=> phase_gate[2] == $past(phase_in[2])) // see RQ9
		else $error("gate does not follow input");
	a_inhibit_off_both: assert property (gate_en[0] && inhibit_dis[0] && phase_in[0] == 2'h3
		|=> phase_gate[0] == 2'h3 && !$past(ovl_set[0])) // see RQ12
		else $error("disabled detection still inhibits");
	a_overlap_sets_err: assert property (s_both_inhibit(0) ##0 flag_option |=> ovl_err[0] && !diagnosis_pin_n) // see RQ11
		else $error("overlap error not set or pin not low");
	a_no_flag_no_err: assert property (!flag_option && !ovl_err[1] && !(wr_ovl && hwdata[BIT_OPTION]) |=> !ovl_err[1]) // see RQ11
		else $error("overlap error set without option");
	a_err_sticky: assert property (ovl_err[2] && !wr_stat |=> ovl_err[2]) // see RQ14
		else $error("overlap error dropped without clear");
	a_err_clear: assert property (wr_stat && hwdata[2] && !ovl_set[2] // see RQ14
		|=> !ovl_err[2] && diagnosis_pin_n == (ovl_err == 3'h0))
		else $error("overlap error not cleared");
	a_pump_uv_off: assert property (vcc_undervoltage |=> !pump_switch_on && !pump_run) // see RQ2
		else $error("pump on under vcc undervoltage");
	a_pump_ov_stop: assert property (pump_overvoltage |=> !pump_run) // see RQ1
		else $error("pump runs at overvoltage");
	a_pump_cmd_off: assert property (ctrl.pump_off |=> !pump_switch_on) // see RQ3
		else $error("pump switch on despite command");
	a_relay_follow: assert property (1'b1 |=> relay_out == ($past(gate_en_relay) ? $past(ctrl.relay_cmd) : 3'h0)) // see RQ5
		else $error("relay output wrong");
	a_limit_window: assert property (ctrl.limit_time == 2'h0 && $changed(phase_gate) && !$changed(ctrl.limit_time)
		|-> current_limit_on [*8]) // see RQ7
		else $error("current limit window too short");
	a_limit_none: assert property (ctrl.limit_time == LIMIT_NONE |=> !current_limit_on) // see RQ7
		else $error("limiting with code 11");
	a_mid_resistor: assert property (!initial_diag_active |=> !midpoint_resistor_on) // see RQ15
		else $error("mid resistor connected outside diagnosis");
endmodule : gpdc_top

// ---- hw/gpdc_pkg.sv ----
// shared constants and types of the gate pre-driver control block
package gpdc_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	// current-limit periods per limit-time code, in ns (plain defaults)
	localparam int LIMIT_CODE0_NS = 1000;
	localparam int LIMIT_CODE1_NS = 2000;
	localparam int LIMIT_CODE2_NS = 4000;
	// least times round up to whole cycles
	localparam int LIMIT_CODE0_CYC = (LIMIT_CODE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_CODE1_CYC = (LIMIT_CODE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_CODE2_CYC = (LIMIT_CODE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_CNT_W = 8;
	localparam logic [1:0] LIMIT_NONE = 2'h3;

	// ------------------------------------------------------------
	// register map (byte addresses) and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PUMP_RELAY = 8'h00;
	localparam logic [7:0] ADDR_OVERLAP = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam int ADDR_W = 8;
	localparam int BIT_PUMP_OFF = 0;
	localparam int BIT_RELAY_LO = 1;
	localparam int BIT_LIMIT_LO = 4;
	localparam int BIT_OPTION = 3;
	localparam int BIT_PUMP_RUN = 4;
	localparam int BIT_PUMP_SW = 5;
	localparam logic [1:0] LIMIT_RESET = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic high;
		logic low;
	} gpdc_pair_t;

	typedef struct packed {
		logic pump_off;
		logic [2:0] relay_cmd;
		logic [1:0] limit_time;
	} gpdc_ctrl_t;
endpackage : gpdc_pkg

// ---- test/gpdc_ctrl_model.sv ----
// behavioural controller and bridge side: pwm inputs and phase enables
`timescale 1ns/100ps
module gpdc_ctrl_model
	import gpdc_pkg::*;
(
	input wire logic hclk,
	input wire logic run,
	input wire gpdc_pkg::gpdc_pair_t [2:0] idle_in,
	output gpdc_pkg::gpdc_pair_t [2:0] phase_in,
	output logic [2:0] gate_en
);
	int seed = 32'h74f6;
	initial begin
		phase_in = '0;
		gate_en = 3'h7;
	end
	// ----------------------------------------
	// random pwm while running, fixed levels between bursts
	// ----------------------------------------
	// overlapping pairs and disabled phases come up often, on purpose
	always @(posedge hclk) begin
		phase_in <= run ? 6'($random(seed)) : idle_in;
		gate_en <= run ? 3'($random(seed)) : 3'h7;
	end
endmodule : gpdc_ctrl_model

// ---- test/gate_predriver_control_tb_top.sv ----
// self-checking bench of the gate pre-driver control block
`timescale 1ns/100ps
module gate_predriver_control_tb_top;
	import gpdc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0;
	gpdc_pair_t [2:0] phase_in, phase_gate, exp_g, idle_in = '0;
	logic [2:0] gate_en, relay_out, exp_err = '0, mask = '0;
	logic en_relay = 1'b0, uv = 1'b0, ov = 1'b0, diag_on = 1'b0, run = 1'b0;
	logic pump_switch_on, pump_run, current_limit_on, midpoint_resistor_on, diagnosis_pin_n, irq;
	logic [3:0] ovr = '0;
	int error_cnt = 0, samples_checked = 0, seed = 32'h74f6, cyc;

	always #20 hclk = ~hclk;
	assign hready = hreadyout;

	gpdc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .phase_in(phase_in), .gate_en(gate_en), .gate_en_relay(en_relay),
		.vcc_undervoltage(uv), .pump_overvoltage(ov), .initial_diag_active(diag_on), .phase_gate(phase_gate),
		.relay_out(relay_out), .pump_switch_on(pump_switch_on), .pump_run(pump_run),
		.current_limit_on(current_limit_on), .midpoint_resistor_on(midpoint_resistor_on),
		.diagnosis_pin_n(diagnosis_pin_n), .irq(irq));
	gpdc_ctrl_model u_ctrl (.hclk(hclk), .run(run), .idle_in(idle_in), .phase_in(phase_in), .gate_en(gate_en));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic final_report;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// one single word transfer; waits on hready, takes read data at the data phase edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 20) begin
			n++;
			@(posedge hclk);
		end
		chk("hready", 1, hready);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 40) begin
			n++;
			@(posedge hclk);
		end
		chk("hready", 1, hready);
		d = hrdata;
		chk("hresp", HRESP_OKAY, hresp);
	endtask : bus

	// ----------------------------------------
	// reference model of the phase gating
	// ----------------------------------------
	// evaluated every edge so the last random sample before idle is modelled too
	always @(posedge hclk) begin
		for (int p = 0; p < 3; p++) begin
			if (phase_in[p].high & phase_in[p].low & ~ovr[p]) begin
				exp_g[p] = '0;
				if (ovr[3]) exp_err[p] = 1'b1;
			end else begin
				exp_g[p] = gate_en[p] ? phase_in[p] : '0;
			end
		end
	end
	always @(negedge hclk) if (hresetn) chk("phase_gate", 32'(exp_g), 32'(phase_gate));

	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		final_report();
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk("status", 32'h30, rd);
		bus(1'b0, ADDR_PUMP_RELAY, 32'h0, rd);
		chk("pump_relay", 32'h30, rd);
		bus(1'b0, 8'h40, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		// pump switch: software off, then undervoltage, then overvoltage
		bus(1'b1, ADDR_PUMP_RELAY, 32'h31, rd);
		repeat (3) @(posedge hclk);
		chk("pump_switch_on", 0, pump_switch_on);
		chk("pump_run", 0, pump_run);
		bus(1'b1, ADDR_PUMP_RELAY, 32'h30, rd);
		uv <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("pump_switch_on", 0, pump_switch_on);
		chk("pump_run", 0, pump_run);
		uv <= 1'b0;
		ov <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("pump_switch_on", 1, pump_switch_on);
		chk("pump_run", 0, pump_run);
		ov <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, ADDR_PUMP_RELAY, {26'h0, 2'h3, i[2:0], 1'b0}, rd);
			en_relay <= i[3];
			repeat (3) @(posedge hclk);
			chk("relay_out", i[3] ? i[2:0] : 3'h0, relay_out);
		end
		// every limit code, each after a fresh gate transition
		for (int c = 0; c < 4; c++) begin
			cyc = (c == 0) ? LIMIT_CODE0_CYC : (c == 1) ? LIMIT_CODE1_CYC : LIMIT_CODE2_CYC;
			bus(1'b1, ADDR_PUMP_RELAY, {26'h0, c[1:0], 4'he}, rd);
			repeat (3) @(posedge hclk);
			idle_in[0].high <= ~idle_in[0].high;
			repeat (3) @(posedge hclk);
			chk("limit_on", c != 3, current_limit_on);
			if (c != 3) begin
				repeat (cyc - 5) @(posedge hclk);
				chk("limit_on", 1, current_limit_on);
				repeat (8) @(posedge hclk);
				chk("limit_on", 0, current_limit_on);
			end
		end
		diag_on <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("midpoint", 1, midpoint_resistor_on);
		diag_on <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("midpoint", 0, midpoint_resistor_on);
		// random bursts, option bit alternating, one burst with interrupts masked
		for (int k = 0; k < 4; k++) begin
			mask = (k == 3) ? 3'h0 : 3'h7;
			bus(1'b1, ADDR_MASK, {29'h0, mask}, rd);
			ovr = {k[0], 3'($random(seed))};
			bus(1'b1, ADDR_OVERLAP, {28'h0, ovr}, rd);
			repeat (2) @(posedge hclk);
			run <= 1'b1;
			repeat (300) @(posedge hclk);
			run <= 1'b0;
			repeat (3) @(posedge hclk);
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chk("errors", exp_err, rd[2:0]);
			chk("diag_n", ~|exp_err, diagnosis_pin_n);
			chk("irq", |(exp_err & mask), irq);
			bus(1'b1, ADDR_STATUS, 32'h7, rd);
			exp_err = '0;
			repeat (3) @(posedge hclk);
			chk("diag_n", 1, diagnosis_pin_n);
			chk("irq", 0, irq);
		end
		final_report();
	end
endmodule : gate_predriver_control_tb_top
